// *** rtl/pss_defs.svh ***
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// management register indexes (byte address is four times the index)
`define PSS_IDX_SUMMARY        8'h10
`define PSS_IDX_BASIC_STATUS   8'h01
`define PSS_IDX_AN_EXPANSION   8'h06
`define PSS_IDX_INT_STATUS     8'h12
`define PSS_IDX_FALSE_CARRIER  8'h14
`define PSS_IDX_RX_ERROR       8'h15
`define PSS_IDX_TENBASE_STATUS 8'h1a

// bus-side registers of this block
`define PSS_ADDR_SUMMARY       12'h040
`define PSS_ADDR_SRC_READ      12'h080
`define PSS_ADDR_IRQ_STATUS    12'h084
`define PSS_ADDR_IRQ_MASK      12'h088

// summary bit positions
`define PSS_BIT_CROSSOVER      14
`define PSS_BIT_RX_ERROR       13
`define PSS_BIT_POLARITY       12
`define PSS_BIT_FALSE_CARRIER  11
`define PSS_BIT_SIGNAL_DETECT  10
`define PSS_BIT_DESCR_LOCK     9
`define PSS_BIT_PAGE_RX        8
`define PSS_BIT_INT_PENDING    7
`define PSS_BIT_REMOTE_FAULT   6
`define PSS_BIT_JABBER         5
`define PSS_BIT_AN_DONE        4
`define PSS_BIT_LOOPBACK       3
`define PSS_BIT_DUPLEX         2
`define PSS_BIT_SPEED          1
`define PSS_BIT_LINK           0

// reset values
`define PSS_RESET_SUMMARY      16'h0002
`define PSS_RESET_MASK         16'h0000

`endif

// *** rtl/pss_pkg.sv ***
package pss_pkg;
	typedef logic [15:0] pss_word_type;
	typedef logic [31:0] pss_bus_type;
	typedef enum logic [1:0] {
		PSS_HTRANS_IDLE   = 2'h0,
		PSS_HTRANS_BUSY   = 2'h1,
		PSS_HTRANS_NONSEQ = 2'h2,
		PSS_HTRANS_SEQ    = 2'h3
	} pss_htrans_type;
endpackage : pss_pkg

// *** rtl/pss_status_summary.sv ***
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

// Contract
// - bit 14 shows whether the receive and transmit pairs are swapped.
// - bit 13 latches high on a receive error and clears on a read of the receive error counter.
// - bit 12 latches high on inverted polarity and clears only on a read of the 10BASE-T status register.
// - bit 11 latches high on a false carrier and clears on a read of the false carrier counter.
// - bit 10 is the 100BASE-TX signal detect, latched low, not meaningful during low-power idle.
// - bit 9 is the descrambler lock, latched low, not meaningful during low-power idle.
// - bit 8 latches high on page received and clears on a read of the expansion register.
// - bit 7 latches high on a pending interrupt and clears on a read of the interrupt status register.
// - bit 6 sets on remote fault and clears on a read of the basic status register or reset.
// - bit 5 mirrors jabber and is not cleared by reading the summary.
// - bit 4 is one while auto-negotiation is complete.
// - bit 3 is one while interface loopback is enabled.
// - bit 2 is one for full duplex and zero for half duplex.
// - bit 1 is one for 10 Mbps and zero for 100 Mbps and resets to one.
// - bit 0 mirrors the link flag and is not cleared by reading the summary.
module pss_status_summary (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     nrst,
	// ahb-lite slave
	input  wire logic                     hsel,
	input  wire logic [11:0]              haddr,
	input  wire pss_pkg::pss_htrans_type  htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire pss_pkg::pss_bus_type     hwdata,
	input  wire logic                     hready,
	output var  pss_pkg::pss_bus_type     hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// phy core status sources (same clock)
	input  wire logic                     crossover,
	input  wire logic                     rx_error_event,
	input  wire logic                     polarity_inverted,
	input  wire logic                     false_carrier_event,
	input  wire logic                     signal_detect,
	input  wire logic                     descrambler_lock,
	input  wire logic                     page_received_event,
	input  wire logic                     interrupt_pending,
	input  wire logic                     remote_fault_event,
	input  wire logic                     jabber,
	input  wire logic                     autoneg_complete,
	input  wire logic                     loopback_enabled,
	input  wire logic                     full_duplex,
	input  wire logic                     speed_10,
	input  wire logic                     link_up,
	// interrupt
	output logic                          irq
);
	import pss_pkg::*;

	// ****************************************
	// bus slave
	// ****************************************

	logic                  ap_valid;
	logic                  dp_read;
	logic                  dp_write;
	logic [11:0]           dp_addr;
	pss_word_type          summary;
	pss_word_type          irq_status;
	pss_word_type          irq_mask;
	pss_word_type          prev_summary;
	logic [7:0]            src_read_idx;
	logic                  src_read_stb;

	assign ap_valid = hsel && hready && (htrans == PSS_HTRANS_NONSEQ || htrans == PSS_HTRANS_SEQ);

	// capture address phase; zero wait states
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dp_read  <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 12'h000;
		end else begin
			dp_read  <= ap_valid && !hwrite;
			dp_write <= ap_valid && hwrite;
			dp_addr  <= haddr;
		end
	end

	// not ready in reset, ready from the first edge after it, always okay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// read data registered at address phase so it stands in the data phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (ap_valid && !hwrite) begin
			unique case (haddr)
				`PSS_ADDR_SUMMARY:    hrdata <= {16'h0000, summary};
				`PSS_ADDR_IRQ_STATUS: hrdata <= {16'h0000, irq_status};
				`PSS_ADDR_IRQ_MASK:   hrdata <= {16'h0000, irq_mask};
				default:              hrdata <= 32'h00000000;
			endcase
		end
	end

	// a write to the source-read port reports that management read a source register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_read_stb <= 1'b0;
			src_read_idx <= 8'h00;
		end else begin
			src_read_stb <= dp_write && dp_addr == `PSS_ADDR_SRC_READ;
			src_read_idx <= hwdata[7:0];
		end
	end

	function automatic logic src_read(input logic [7:0] idx);
		src_read = src_read_stb && src_read_idx == idx;
	endfunction : src_read

	// ****************************************
	// summary register
	// ****************************************

	// per-bit flops, one process per bit so every bit has a single driver
	logic                  crossover_q;
	logic                  rx_error_q;
	logic                  polarity_q;
	logic                  false_carrier_q;
	logic                  signal_detect_q;
	logic                  signal_detect_held;
	logic                  next_signal_detect_held;
	logic                  descr_lock_q;
	logic                  descr_lock_held;
	logic                  next_descr_lock_held;
	logic                  page_rx_q;
	logic                  int_pending_q;
	logic                  remote_fault_q;
	logic                  jabber_q;
	logic                  an_done_q;
	logic                  loopback_q;
	logic                  duplex_q;
	logic                  speed_q;
	logic                  link_q;
	logic                  summary_read;

	// summary read seen in its data phase, after the word was captured
	assign summary_read = dp_read && dp_addr == `PSS_ADDR_SUMMARY;

	// set wins over a clear in the same cycle so no event is lost
	function automatic logic latch_high(input logic set, input logic q, input logic clr);
		latch_high = set || (q && !clr);
	endfunction : latch_high

	// hold flag of a latch-low bit: a drop sets it, a summary read with the source up clears it
	function automatic logic latch_low_hold(input logic live, input logic held, input logic rd);
		latch_low_hold = !live || (held && !rd);
	endfunction : latch_low_hold

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			crossover_q <= 1'b0;
		else
			crossover_q <= crossover;
	end

	// jabber mirror, a summary read leaves it alone
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			jabber_q <= 1'b0;
		else
			jabber_q <= jabber;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			an_done_q <= 1'b0;
		else
			an_done_q <= autoneg_complete;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			loopback_q <= 1'b0;
		else
			loopback_q <= loopback_enabled;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			duplex_q <= 1'b0;
		else
			duplex_q <= full_duplex;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			speed_q <= 1'b1;
		else
			speed_q <= speed_10;
	end

	// link mirror, a summary read leaves it alone
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			link_q <= 1'b0;
		else
			link_q <= link_up;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rx_error_q <= 1'b0;
		else
			rx_error_q <= latch_high(rx_error_event, rx_error_q, src_read(`PSS_IDX_RX_ERROR));
	end

	// polarity latch, only the source read clears it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			polarity_q <= 1'b0;
		else
			polarity_q <= latch_high(polarity_inverted, polarity_q, src_read(`PSS_IDX_TENBASE_STATUS));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			false_carrier_q <= 1'b0;
		else
			false_carrier_q <= latch_high(false_carrier_event, false_carrier_q, src_read(`PSS_IDX_FALSE_CARRIER));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			page_rx_q <= 1'b0;
		else
			page_rx_q <= latch_high(page_received_event, page_rx_q, src_read(`PSS_IDX_AN_EXPANSION));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			int_pending_q <= 1'b0;
		else
			int_pending_q <= latch_high(interrupt_pending, int_pending_q, src_read(`PSS_IDX_INT_STATUS));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			remote_fault_q <= 1'b0;
		else
			remote_fault_q <= latch_high(remote_fault_event, remote_fault_q, src_read(`PSS_IDX_BASIC_STATUS));
	end

	assign next_signal_detect_held = latch_low_hold(signal_detect, signal_detect_held, summary_read);

	// signal detect latch-low; meaningless in low-power idle, software filters it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			signal_detect_held <= 1'b0;
			signal_detect_q    <= 1'b0;
		end else begin
			signal_detect_held <= next_signal_detect_held;
			signal_detect_q    <= !next_signal_detect_held;
		end
	end

	assign next_descr_lock_held = latch_low_hold(descrambler_lock, descr_lock_held, summary_read);

	// descrambler lock latch-low; a short loss stays visible until read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			descr_lock_held <= 1'b0;
			descr_lock_q    <= 1'b0;
		end else begin
			descr_lock_held <= next_descr_lock_held;
			descr_lock_q    <= !next_descr_lock_held;
		end
	end

	// reserved zero, no write path reaches any bit
	assign summary = {1'b0, crossover_q, rx_error_q, polarity_q, false_carrier_q, signal_detect_q, descr_lock_q,
		page_rx_q, int_pending_q, remote_fault_q, jabber_q, an_done_q, loopback_q, duplex_q, speed_q, link_q};

	// ****************************************
	// interrupt
	// ****************************************

	// previous summary for change detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			prev_summary <= `PSS_RESET_SUMMARY;
		else
			prev_summary <= summary;
	end

	// sticky change bits; cleared on the edge that captures the read word, so no change slips between
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			irq_status <= 16'h0000;
		else if (ap_valid && !hwrite && haddr == `PSS_ADDR_IRQ_STATUS)
			irq_status <= summary ^ prev_summary;
		else
			irq_status <= irq_status | (summary ^ prev_summary);
	end

	// mask register, low 16 bits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			irq_mask <= `PSS_RESET_MASK;
		else if (dp_write && dp_addr == `PSS_ADDR_IRQ_MASK)
			irq_mask <= hwdata[15:0];
	end

	// level output, one cycle behind status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

endmodule : pss_status_summary
`default_nettype wire

// *** verif/pss_status_summary_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***
// summary bus checks
// ***
module pss_status_summary_monitor (
	// bus side
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic                    hsel,
	input wire logic [11:0]             haddr,
	input wire pss_pkg::pss_htrans_type htrans,
	input wire logic                    hwrite,
	input wire logic                    hready,
	input wire pss_pkg::pss_bus_type    hrdata,
	input wire logic                    hreadyout,
	input wire logic                    hresp,
	// sources
	input wire logic                    crossover,
	input wire logic                    rx_error_event
);
	import pss_pkg::*;
	// any accepted request, and the read among them
	wire req = hsel && hready && htrans[1];
	wire rd = req && !hwrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_sum; rd && haddr == 12'h040; endsequence
	sequence s_err; rx_error_event ##[1:3] s_sum; endsequence
	a_top_zero: assert property (s_sum |=> hrdata[31:15] == 17'h0) else $error("top bits set");
	a_cross_shown: assert property (s_sum ##0 $stable(crossover) |=> hrdata[14] == $past(crossover))
		else $error("crossover bit wrong");
	a_rxerr_latch: assert property (s_err |=> hrdata[13]) else $error("rx error not latched");
	a_unmapped_zero: assert property (rd && !(haddr inside {12'h040, 12'h080, 12'h084, 12'h088}) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	// read data must not wander between reads
	a_rdata_held: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
	a_ready_high: assert property ($past(nrst, 2) |-> hreadyout) else $error("wait state seen");
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_zero_wait: assert property (req |=> hreadyout && !hresp) else $error("data phase stalled");
endmodule : pss_status_summary_monitor
`default_nettype wire

// *** verif/pss_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***
// management host, single word transfers
// ***
module pss_host_model (
	// clock and slave answer
	input  wire logic                    clk,
	input  wire logic                    hready,
	input  wire pss_pkg::pss_bus_type    hrdata,
	// request
	output var  logic                    hsel,
	output var  logic [11:0]             haddr,
	output var  pss_pkg::pss_htrans_type htrans,
	output var  logic                    hwrite,
	output var  logic [2:0]              hsize,
	output var  pss_pkg::pss_bus_type    hwdata
);
	import pss_pkg::*;
	// set when a wait ran out; the bench counts it
	logic stuck = 1'b0;
	// idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = PSS_HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// bounded wait, no slave timing assumed
	task automatic wait_ready(inout int n);
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
	endtask : wait_ready
	// address phase, then data phase
	task automatic xfer(input logic wr, input logic [11:0] a, input pss_bus_type wd, output pss_bus_type rd);
		int n = 0;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= PSS_HTRANS_NONSEQ;
		wait_ready(n);
		hsel <= 1'b0;
		htrans <= PSS_HTRANS_IDLE;
		hwdata <= wd;
		wait_ready(n);
		rd = hrdata;
		if (n >= 64)
			stuck = 1'b1;
	endtask : xfer
endmodule : pss_host_model
`default_nettype wire

// *** verif/tb_phy_status_summary_register.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
// ***
// summary register bench
// ***
module tb_phy_status_summary_register;
	import pss_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	// source levels, index equals summary bit
	logic [14:0] src = 15'h0002;
	wire logic   hsel, hwrite, hready, hresp, irq;
	wire logic [11:0] haddr;
	wire logic [2:0]  hsize;
	wire pss_htrans_type htrans;
	wire pss_bus_type hwdata, hrdata;
	pss_bus_type d;
	int          n_fail = 0;
	int          n_compared = 0;
	always #2.5 clk = ~clk;
	pss_status_summary u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.crossover(src[14]), .rx_error_event(src[13]), .polarity_inverted(src[12]), .false_carrier_event(src[11]),
		.signal_detect(src[10]), .descrambler_lock(src[9]), .page_received_event(src[8]), .irq(irq),
		.interrupt_pending(src[7]), .remote_fault_event(src[6]), .jabber(src[5]), .autoneg_complete(src[4]),
		.loopback_enabled(src[3]), .full_duplex(src[2]), .speed_10(src[1]), .link_up(src[0]));
	pss_host_model u_host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick
	task automatic expect_rd(input logic [11:0] a, input pss_bus_type e);
		u_host.xfer(1'b0, a, 32'h0, d);
		`CHK(d, e)
	endtask : expect_rd
	task automatic finish_test;
		if (u_host.stuck)
			n_fail++;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// a wait that ran out ends the run at once
	always @(posedge u_host.stuck)
		finish_test();
	// one live level at a time, speed by inversion
	task automatic t_levels;
		int b[7] = '{14, 5, 4, 3, 2, 1, 0};
		foreach (b[i]) begin
			src <= 15'h0002 ^ (15'h1 << b[i]);
			tick(2);
			expect_rd(12'h040, 32'h0002 ^ (32'h1 << b[i]));
			src <= 15'h0002;
			tick(2);
		end
		$display("levels done");
	endtask : t_levels
	// one-cycle pulses; only the own source read clears
	task automatic t_latch;
		int b[6] = '{13, 12, 11, 8, 7, 6};
		logic [7:0] x[6] = '{8'h15, 8'h1a, 8'h14, 8'h06, 8'h12, 8'h01};
		foreach (b[i]) begin
			src <= 15'h0002 | (15'h1 << b[i]);
			tick(1);
			src <= 15'h0002;
			tick(2);
			expect_rd(12'h040, 32'h0002 | (32'h1 << b[i]));
			expect_rd(12'h040, 32'h0002 | (32'h1 << b[i]));
			u_host.xfer(1'b1, 12'h080, {24'h0, x[i]}, d);
			tick(3);
			expect_rd(12'h040, 32'h0002);
		end
		$display("latch done");
	endtask : t_latch
	// a short drop sticks until read; writes change nothing
	task automatic t_low;
		src <= 15'h0602;
		tick(2);
		u_host.xfer(1'b0, 12'h040, 32'h0, d);
		expect_rd(12'h040, 32'h0602);
		src <= 15'h0002;
		tick(1);
		src <= 15'h0602;
		tick(2);
		u_host.xfer(1'b1, 12'h040, 32'hffffffff, d);
		expect_rd(12'h040, 32'h0002);
		expect_rd(12'h040, 32'h0602);
		expect_rd(12'h0fc, 32'h0);
		$display("latch low done");
	endtask : t_low
	// irq follows masked change, read clears it
	task automatic t_irq;
		u_host.xfer(1'b0, 12'h084, 32'h0, d);
		u_host.xfer(1'b1, 12'h088, 32'h1, d);
		expect_rd(12'h088, 32'h1);
		`CHK(irq, 1'b0)
		src <= 15'h0603;
		tick(4);
		`CHK(irq, 1'b1)
		expect_rd(12'h084, 32'h1);
		tick(3);
		`CHK(irq, 1'b0)
		u_host.xfer(1'b1, 12'h088, 32'h0, d);
		src <= 15'h0602;
		tick(4);
		`CHK(irq, 1'b0)
		expect_rd(12'h084, 32'h1);
		$display("irq done");
	endtask : t_irq
	initial begin
		tick(2);
		nrst <= 1'b1;
		tick(1);
		expect_rd(12'h040, 32'h0002);
		expect_rd(12'h088, 32'h0);
		t_levels();
		t_latch();
		t_low();
		t_irq();
		finish_test();
	end
endmodule : tb_phy_status_summary_register
bind pss_status_summary pss_status_summary_monitor u_mon (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.crossover(crossover), .rx_error_event(rx_error_event));
`default_nettype wire
